// [core/bsis_map.svh]
`ifndef BSIS_MAP_SVH
`define BSIS_MAP_SVH
// ===========================================================
// Dword addresses of the group
`define BSIS_DW_LAT 6'h06
`define BSIS_DW_IO 6'h07
// ===========================================================
// Status field positions
`define BSIS_ST_FBB 23
`define BSIS_ST_DPD 24
`define BSIS_ST_STA 27
`define BSIS_ST_RTA 28
`define BSIS_ST_RMA 29
`define BSIS_ST_RSE 30
`define BSIS_ST_DPE 31
// ===========================================================
// Fixed values and resets
`define BSIS_IO32_IND 4'h1
`define BSIS_DEVSEL_MED 2'h1
`define BSIS_LAT_RST 8'h00
`define BSIS_NIB_RST 4'h0
`endif

// [core/bsis_pkg.sv]
package bsis_pkg;
   // Latency timer states for a secondary master burst
   typedef enum logic [1:0] {BSIS_IDLE, BSIS_RUN, BSIS_EXP} bsis_lat_e;
   // Sticky status flags, bits 31..27 and 24
   typedef logic [5:0] bsis_flags_t;
endpackage : bsis_pkg

// [core/bsis_regs.sv]
`timescale 1ns/10ps
`include "bsis_map.svh"
module bsis_regs
   import bsis_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Configuration access, dword address with byte enables
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [5:0] cfg_dw,
   input wire logic [3:0] cfg_be_n,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   // Secondary master burst, same clock
   input wire logic sec_frame_start,
   input wire logic sec_burst_end,
   input wire logic sec_gnt_n,
   input wire logic sec_mwi,
   output logic lat_expired,
   output logic end_after_first,
   // I/O decode, upper halves from elsewhere
   input wire logic [15:0] io_base_hi,
   input wire logic [15:0] io_limit_hi,
   input wire logic [31:0] io_addr,
   output logic io_in_window,
   // Secondary bus events, same clock
   input wire logic sec_is_master,
   input wire logic sec_parity_err,
   input wire logic sec_perr_seen,
   input wire logic parity_resp_en,
   input wire logic sig_target_abort,
   input wire logic rcv_target_abort,
   input wire logic rcv_master_abort,
   input wire logic sec_serr_seen
);
   // ===========================================================
   // Register state
   logic [7:0] lat_q, lat_d;             // Secondary latency timer
   logic [3:0] iob_q, iob_d;             // I/O base bits 15:12
   logic [3:0] iol_q, iol_d;             // I/O limit bits 15:12
   bsis_flags_t flg_q, flg_d;            // {31,30,29,28,27,24}
   logic [31:0] rd_q, rd_d;              // Read data register
   // Byte lane enable for a write
   function automatic logic lane(input logic [3:0] be, input int i);
      lane = cfg_wr && !be[i];
   endfunction : lane
   // Clear request per flag, only on the status dword lane 3
   logic wr_io;
   logic [5:0] clr, set;
   // Status half as it reads
   function automatic logic [15:0] status_view(input bsis_flags_t f);
      logic [15:0] s;
      s = 16'h0000;
      s[`BSIS_ST_FBB-16] = 1'b1;
      s[`BSIS_ST_DPD-16] = f[0];
      s[10:9] = `BSIS_DEVSEL_MED;
      s[15:11] = f[5:1];
      status_view = s;
   endfunction : status_view
   // ===========================================================
   // Register file next values
   always_comb begin
      wr_io = cfg_dw == `BSIS_DW_IO;
      lat_d = lat_q;
      iob_d = iob_q;
      iol_d = iol_q;
      if (cfg_dw == `BSIS_DW_LAT && lane(cfg_be_n, 3)) begin
         lat_d = cfg_wdata[31:24];
      end
      if (wr_io && lane(cfg_be_n, 0)) begin
         iob_d = cfg_wdata[7:4];
      end
      if (wr_io && lane(cfg_be_n, 1)) begin
         iol_d = cfg_wdata[15:12];
      end
      // Clears land per byte lane of the status half
      clr = 6'h00;
      if (wr_io && lane(cfg_be_n, 3)) begin
         clr[5:1] = cfg_wdata[31:27];
      end
      if (wr_io && lane(cfg_be_n, 3)) begin
         clr[0] = cfg_wdata[24];
      end
      // Event sources
      set[0] = sec_is_master && parity_resp_en &&
               (sec_parity_err || sec_perr_seen);
      set[1] = sig_target_abort;
      set[2] = rcv_target_abort;
      set[3] = rcv_master_abort;
      set[4] = sec_serr_seen;
      set[5] = sec_parity_err;
      // Set wins over the clear in the same cycle
      flg_d = (flg_q & ~clr) | set;
      // Read mux, registered to keep outputs on flops
      rd_d = rd_q;
      if (cfg_rd) begin
         unique case (cfg_dw)
            `BSIS_DW_LAT: rd_d = {lat_q, 24'h000000};
            `BSIS_DW_IO: rd_d = {status_view(flg_q), iol_q,
                                 `BSIS_IO32_IND, iob_q,
                                 `BSIS_IO32_IND};
            default: rd_d = 32'h00000000;
         endcase
      end
   end
   // Register file flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lat_q <= `BSIS_LAT_RST;
         iob_q <= `BSIS_NIB_RST;
         iol_q <= `BSIS_NIB_RST;
         flg_q <= 6'h00;
         rd_q <= 32'h00000000;
      end else begin
         lat_q <= lat_d;
         iob_q <= iob_d;
         iol_q <= iol_d;
         flg_q <= flg_d;
         rd_q <= rd_d;
      end
   end
   assign cfg_rdata = rd_q;
   // Register file checks, next to the writes and events they guard
   iob_write_a: assert property (@(posedge clk)
      disable iff (!resetn) (cfg_wr && cfg_dw == `BSIS_DW_IO &&
      !cfg_be_n[0]) |=> iob_q == $past(cfg_wdata[7:4]))
      else $error("io base nibble not written");
   iol_write_a: assert property (@(posedge clk)
      disable iff (!resetn) (cfg_wr && cfg_dw == `BSIS_DW_IO &&
      !cfg_be_n[1]) |=> iol_q == $past(cfg_wdata[15:12]))
      else $error("io limit nibble not written");
   // A zero written over the set bit 31 detected parity flag must leave it standing
   keep_zero_a: assert property (@(posedge clk)
      disable iff (!resetn) (flg_q[5] && !clr[5]) |=> flg_q[5])
      else $error("detected parity flag lost");
   dpd_set_a: assert property (@(posedge clk)
      disable iff (!resetn) (sec_is_master && parity_resp_en &&
      (sec_parity_err || sec_perr_seen)) |=> flg_q[0])
      else $error("data parity flag not set");
   sta_set_a: assert property (@(posedge clk)
      disable iff (!resetn) sig_target_abort |=> flg_q[1])
      else $error("signalled abort flag not set");
   rta_set_a: assert property (@(posedge clk)
      disable iff (!resetn) rcv_target_abort |=> flg_q[2])
      else $error("received abort flag not set");
   serr_set_a: assert property (@(posedge clk)
      disable iff (!resetn) sec_serr_seen |=> flg_q[4])
      else $error("system error flag not set");
   cov_setwin: cover property (@(posedge clk) disable iff (!resetn)
      sec_serr_seen && clr[4]);
   // ===========================================================
   // Latency timer on the secondary master
   bsis_lat_e st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic exp_q, exp_d, eaf_q, eaf_d;
   // A frame start seen outside idle is ignored: the count belongs to
   // the burst in flight until its end is reported
   // Next state; expiry means end the burst once grant is gone
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      exp_d = 1'b0;
      eaf_d = 1'b0;
      unique case (st_q)
         BSIS_IDLE: begin
            if (sec_frame_start) begin
               cnt_d = 8'h01;
               st_d = (lat_q == 8'h00) ? BSIS_EXP : BSIS_RUN;
            end
         end
         BSIS_RUN: begin
            cnt_d = cnt_q + 8'h01;
            if (cnt_q >= lat_q) begin
               st_d = BSIS_EXP;
            end
         end
         BSIS_EXP: begin
            exp_d = 1'b1;
            // Zero timer: stop after first data phase
            eaf_d = (lat_q == 8'h00) && sec_gnt_n && !sec_mwi;
         end
      endcase
      if (sec_burst_end) begin
         st_d = BSIS_IDLE;
         exp_d = 1'b0;
         eaf_d = 1'b0;
      end
   end
   // Timer flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= BSIS_IDLE;
         cnt_q <= 8'h00;
         exp_q <= 1'b0;
         eaf_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         exp_q <= exp_d;
         eaf_q <= eaf_d;
      end
   end
   assign lat_expired = exp_q;
   assign end_after_first = eaf_q;
   // Timer checks; a burst end in the gap forgives the expiry
   lat_expire_a: assert property (@(posedge clk)
      disable iff (!resetn) (st_q == BSIS_RUN && cnt_q >= lat_q &&
      !sec_burst_end) |=> ##1 (lat_expired || $past(sec_burst_end)))
      else $error("timer did not expire at count");
   // Memory write and invalidate never stops after the first transfer
   mwi_exempt_a: assert property (@(posedge clk)
      disable iff (!resetn) sec_mwi |=> !end_after_first)
      else $error("early end during invalidate");
   gnt_held_a: assert property (@(posedge clk)
      disable iff (!resetn) !sec_gnt_n |=> !end_after_first)
      else $error("early end with grant held");
   // ===========================================================
   // I/O window compare, registered; 4KB grain from the nibbles
   logic win_q, win_d;
   logic [31:0] lo_a, hi_a;
   always_comb begin
      lo_a = {io_base_hi, iob_q, 12'h000};
      hi_a = {io_limit_hi, iol_q, 12'hfff};
      win_d = (io_addr >= lo_a) && (io_addr <= hi_a);
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         win_q <= 1'b0;
      end else begin
         win_q <= win_d;
      end
   end
   assign io_in_window = win_q;
   // Window checks in page terms, independent of the compare above
   win_low_a: assert property (@(posedge clk)
      disable iff (!resetn) (io_addr[31:12] < {io_base_hi, iob_q}) |=>
      !io_in_window)
      else $error("address below base forwarded");
   win_high_a: assert property (@(posedge clk)
      disable iff (!resetn) (io_addr[31:12] > {io_limit_hi, iol_q}) |=>
      !io_in_window)
      else $error("address above limit forwarded");
   // ===========================================================
   // Checks
   // Sticky flags and their clears
   sticky_set_a: assert property (@(posedge clk)
      disable iff (!resetn) rcv_master_abort |=> flg_q[3])
      else $error("master abort flag not set");
   set_wins_a: assert property (@(posedge clk)
      disable iff (!resetn) (sec_serr_seen && clr[4]) |=> flg_q[4])
      else $error("clear beat set");
   w1c_clear_a: assert property (@(posedge clk)
      disable iff (!resetn) (clr[2] && !set[2]) |=> !flg_q[2])
      else $error("flag not cleared");
   dpd_gate_a: assert property (@(posedge clk)
      disable iff (!resetn) (!sec_is_master && flg_q[0] == 1'b0) |=>
      !flg_q[0])
      else $error("bit 24 set without master");
   perr_flag_a: assert property (@(posedge clk)
      disable iff (!resetn) sec_parity_err |=> flg_q[5])
      else $error("parity flag not set");
   // Fixed read fields: bits 23:16 hold only the fast back-to-back one
   rd_const_a: assert property (@(posedge clk)
      disable iff (!resetn) (cfg_rd && cfg_dw == `BSIS_DW_IO) |=>
      (cfg_rdata[23:16] == 8'h80 && cfg_rdata[26:25] == 2'h1 &&
       cfg_rdata[11:8] == 4'h1 && cfg_rdata[3:0] == 4'h1))
      else $error("fixed fields wrong");
   lat_write_a: assert property (@(posedge clk)
      disable iff (!resetn) (cfg_dw == `BSIS_DW_LAT && cfg_wr &&
      !cfg_be_n[3]) |=> lat_q == $past(cfg_wdata[31:24]))
      else $error("timer not written");
   lat_zero_a: assert property (@(posedge clk)
      disable iff (!resetn) (st_q == BSIS_IDLE && sec_frame_start &&
      lat_q == 8'h00 && !sec_burst_end) |=>
      ##1 (lat_expired || sec_burst_end || $past(sec_burst_end)))
      else $error("zero timer no expiry");
   cov_expire: cover property (@(posedge clk) disable iff (!resetn)
      lat_expired);
   cov_eaf: cover property (@(posedge clk) disable iff (!resetn)
      end_after_first);
   cov_win: cover property (@(posedge clk) disable iff (!resetn)
      io_in_window);
endmodule : bsis_regs

// [dv/bsis_host.sv]
`timescale 1ns/10ps
// =====
// Host configuration master on the primary side
module bsis_host (
   // Clock
   input wire logic clk,
   // Configuration cycle
   output logic cfg_wr,
   output logic cfg_rd,
   output logic [5:0] cfg_dw,
   output logic [3:0] cfg_be_n,
   output logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata
);
   // Idle bus at time zero
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_dw = 6'h00;
      cfg_be_n = 4'hf;
      cfg_wdata = 32'h0;
   end
   // One write held across one rising edge
   task automatic wr(input logic [5:0] dw, input logic [3:0] be_n,
      input logic [31:0] d);
      @(negedge clk);
      cfg_dw = dw;
      cfg_be_n = be_n;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
      cfg_wdata = ~d; // Stale data must never look valid
   endtask : wr
   // One read; data is taken a cycle and a half after the rising edge that samples the strobe
   task automatic rd(input logic [5:0] dw, output logic [31:0] d);
      @(negedge clk);
      cfg_dw = dw;
      cfg_rd = 1'b1;
      @(negedge clk);
      cfg_rd = 1'b0;
      @(negedge clk);
      d = cfg_rdata;
   endtask : rd
endmodule : bsis_host

// [dv/bsis_regs_tb.sv]
`timescale 1ns/10ps
// =====
// Bench for the secondary timer, window and status group
module bsis_regs_tb;
   // Clock, reset, counters
   logic clk = 1'b0;
   logic resetn = 1'b0;
   int num_errors = 0;
   int total_checks = 0;
   // Burst and event stimulus; ev is {serr,rma,rta,sta,perr,par}
   logic sfs = 1'b0, sbe = 1'b0, gnt_n = 1'b0, mwi = 1'b0;
   logic mst = 1'b0, pen = 1'b0;
   logic [5:0] ev = 6'h00;
   logic [31:0] addr = 32'h0, rv;
   // Upper window halves differ so a swapped source shows
   logic [15:0] bhi = 16'h0001, lhi = 16'h0002;
   // Design outputs and host wires
   logic wr, rd, le, eaf, inw;
   logic [5:0] dw;
   logic [3:0] be_n;
   logic [31:0] wd, rdata;
   always #5 clk = ~clk;
   bsis_host host (.clk(clk), .cfg_wr(wr), .cfg_rd(rd), .cfg_dw(dw),
      .cfg_be_n(be_n), .cfg_wdata(wd), .cfg_rdata(rdata));
   bsis_regs dut (.clk(clk), .resetn(resetn), .cfg_wr(wr), .cfg_rd(rd),
      .cfg_dw(dw), .cfg_be_n(be_n), .cfg_wdata(wd), .cfg_rdata(rdata),
      .sec_frame_start(sfs), .sec_burst_end(sbe), .sec_gnt_n(gnt_n),
      .sec_mwi(mwi), .lat_expired(le), .end_after_first(eaf),
      .io_base_hi(bhi), .io_limit_hi(lhi), .io_addr(addr),
      .io_in_window(inw), .sec_is_master(mst), .sec_parity_err(ev[0]),
      .sec_perr_seen(ev[1]), .parity_resp_en(pen),
      .sig_target_abort(ev[2]), .rcv_target_abort(ev[3]),
      .rcv_master_abort(ev[4]), .sec_serr_seen(ev[5]));
   // =====
   // Compare and verdict
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         $display("MISMATCH %s exp %h seen %h", n, e, s);
         num_errors++;
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test
   // =====
   // Reset values, writable fields, read-only lane, unmapped dword
   task automatic t_regs;
      host.rd(6'h06, rv);
      chk("timer_rst", 32'h0, rv & 32'hff000000);
      host.rd(6'h07, rv);
      chk("io_st_rst", 32'h02800101, rv);
      host.wr(6'h06, 4'h7, 32'ha5000000);
      host.rd(6'h06, rv);
      chk("timer", 32'ha5000000, rv & 32'hff000000);
      // Lane 2 is offered too; it must not stick
      host.wr(6'h07, 4'h8, 32'h00ff5f3f);
      host.rd(6'h07, rv);
      chk("io_st", 32'h02805131, rv);
      host.wr(6'h10, 4'h0, 32'hffffffff);
      host.rd(6'h10, rv);
      chk("unmapped", 32'h0, rv);
      $display("done regs");
   endtask : t_regs
   // Window edges: base 0x13000, top 0x25fff
   task automatic t_window;
      logic [31:0] a[4] = '{32'h00013000, 32'h00012fff,
         32'h00025fff, 32'h00026000};
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         addr = a[i];
         @(negedge clk);
         chk("in_window", 32'(!i[0]), 32'(inw));
      end
      $display("done window");
   endtask : t_window
   // Each flag set, kept by a zero write, cleared by a one
   task automatic t_flags;
      logic [31:0] m[7] = '{32'h80000000, 32'h01000000, 32'h08000000,
         32'h10000000, 32'h20000000, 32'h40000000, 32'h0};
      logic [5:0] e[7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20,
         6'h02};
      for (int k = 0; k < 7; k++) begin
         @(negedge clk);
         mst = (k == 1) || (k == 6);
         pen = (k == 1);
         ev = e[k];
         @(negedge clk);
         ev = 6'h00;
         host.wr(6'h07, 4'h7, 32'h0);
         host.rd(6'h07, rv);
         chk("flag_set", 32'h02805131 | m[k], rv);
         host.wr(6'h07, 4'h7, m[k]);
         host.rd(6'h07, rv);
         chk("flag_clr", 32'h02805131, rv);
      end
      // Event lands on the same edge as its clear
      fork
         host.wr(6'h07, 4'h7, 32'h40000000);
         begin
            @(negedge clk);
            ev = 6'h20;
            @(negedge clk);
            ev = 6'h00;
         end
      join
      host.rd(6'h07, rv);
      chk("set_wins", 32'h42805131, rv);
      $display("done flags");
   endtask : t_flags
   // Frame start pulse
   task automatic start;
      @(negedge clk);
      sfs = 1'b1;
      @(negedge clk);
      sfs = 1'b0;
   endtask : start
   // Timer expiry at count 3, then zero timer with grant gone
   task automatic t_timer;
      int n;
      host.wr(6'h06, 4'h7, 32'h03000000);
      start();
      repeat (3) @(negedge clk);
      chk("expire_early", 32'h0, 32'(le));
      @(negedge clk);
      chk("expire", 32'h1, 32'(le));
      sbe = 1'b1;
      @(negedge clk);
      sbe = 1'b0;
      host.wr(6'h06, 4'h7, 32'h0);
      gnt_n = 1'b1;
      start();
      for (n = 0; n < 8 && eaf !== 1'b1; n++)
         @(negedge clk);
      chk("end_first", 32'h1, 32'(eaf));
      if (eaf !== 1'b1)
         finish_test();
      // Memory write and invalidate is exempt
      sbe = 1'b1;
      mwi = 1'b1;
      @(negedge clk);
      sbe = 1'b0;
      start();
      repeat (6) @(negedge clk);
      chk("mwi_keeps", 32'h0, 32'(eaf));
      // Grant still held: the zero timer expires but does not cut
      sbe = 1'b1;
      mwi = 1'b0;
      gnt_n = 1'b0;
      @(negedge clk);
      sbe = 1'b0;
      start();
      repeat (3) @(negedge clk);
      chk("gnt_keeps", 32'h0, 32'(eaf));
      chk("zero_expire", 32'h1, 32'(le));
      $display("done timer");
   endtask : t_timer
   // Mid-run reset returns every field and both timer outputs to their reset values
   task automatic t_reset;
      host.wr(6'h06, 4'h7, 32'h5a000000);
      @(negedge clk);
      ev = 6'h10;
      @(negedge clk);
      ev = 6'h00;
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      chk("rst_out", 32'h0, {30'h0, le, eaf});
      resetn = 1'b1;
      host.rd(6'h06, rv);
      chk("rst_timer", 32'h0, rv);
      host.rd(6'h07, rv);
      chk("rst_io_st", 32'h02800101, rv);
      $display("done reset");
   endtask : t_reset
   // =====
   // Main sequence
   initial begin
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      t_regs();
      t_window();
      t_flags();
      t_timer();
      t_reset();
      finish_test();
   end
endmodule : bsis_regs_tb
